// file: hw/sfm_cfg.svh
// Serial format block constants
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// Register indices, byte address is 4x
`define SFM_IDX_FUNC_MODE   6'h03
`define SFM_IDX_FORMAT      6'h04
`define SFM_IDX_MISC        6'h05
`define SFM_IDX_CLK_CTRL    6'h06
`define SFM_IDX_MIX_FIRST   6'h0F
`define SFM_IDX_MIX_LAST    6'h1B
`define SFM_IDX_RX_MODE     6'h1E
`define SFM_IDX_STATUS      6'h20

// Field positions
`define SFM_F_DIF           7:6
`define SFM_F_ADC_SINGLE_LINE_SEL        5:4
`define SFM_F_DAC_SINGLE_LINE_SEL        3:2
`define SFM_B_AUX_RJ16      1
`define SFM_B_CONV_RJ16     0
`define SFM_B_EXT_SCLK      7
`define SFM_B_HIZ_MCLK      6
`define SFM_B_HOLD          4
`define SFM_B_ROLLOFF       3
`define SFM_B_HPF_HOLD      2
`define SFM_B_CONV_ROLE     1
`define SFM_B_AUX_ROLE      0
`define SFM_B_DAC_DEEMPH_ENABLE       1
`define SFM_B_RX_DEM        0
`define SFM_B_FORCE_LOCK    0
`define SFM_F_MAN_RATE      5:4

// Reset values
`define SFM_RST_FORMAT      8'h40
`define SFM_RST_MISC        8'h00
`define SFM_RST_BYTE        8'h00

// Rate codes and reserved code
`define SFM_RATE_NONE       2'h0
`define SFM_RATE_32K        2'h1
`define SFM_RATE_44K        2'h2
`define SFM_RATE_48K        2'h3
`define SFM_CODE_RSVD       2'h3

// Bus answers
`define SFM_RESP_OKAY       2'h0
`define SFM_RESP_SLVERR     2'h2

// Timing
`define SFM_CLK_PERIOD_NS   40
`define SFM_BCLK_HALF_CYC   2
`define SFM_HALF_FRAME_BITS 32
`define SFM_FRAME_TMO_US    1000

`endif

// file: hw/sfm_pkg.sv
// Types shared by the serial format block
package sfm_pkg;

    typedef enum logic [2:0] {
        SFM_FMT_LJ,
        SFM_FMT_I2S,
        SFM_FMT_RJ,
        SFM_FMT_OL1,
        SFM_FMT_OL2
    } sfm_fmt_t;

    typedef enum logic [1:0] {
        SFM_DEEMPH_OFF,
        SFM_DEEMPH_32K,
        SFM_DEEMPH_44K,
        SFM_DEEMPH_48K
    } sfm_deemph_t;

endpackage

// file: hw/sfm_ctrl.sv
// Serial port format, port role and misc control with AXI4-Lite registers
// Operation
// - DAC de-emphasis at detected rate
// - De-emphasis only at 32, 44.1, 48 kHz
// - Forced lock: manual code picks rate
// - Receiver de-emphasis on status emphasis
// - Forced lock ignores detected rate
// - Format field sets both ports, reset I2S
// - ADC one-line mode
// - DAC one-line mode
// - Aux RJ word width
// - Converter RJ word width
// - External ADC bit clock source
// - Tristate recovered clock output
// - Hold freezes mixing updates
// - Roll-off select
// - High-pass hold
// - Converter master drives clocks
// - Aux master drives clocks
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "sfm_cfg.svh"

module sfm_ctrl
    import sfm_pkg::*;
#(
    parameter int ADDR_W        = 8,
    parameter int BCLK_HALF     = `SFM_BCLK_HALF_CYC,
    parameter int HALF_FRAME    = `SFM_HALF_FRAME_BITS,
    parameter int FRAME_TMO_CYC = (`SFM_FRAME_TMO_US * 1000) / `SFM_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Receiver status from same-clock logic
    input  wire logic [1:0]        detected_rate_i,
    input  wire logic              rx_emphasis_i,
    // Converter serial port pins
    input  wire logic              conv_port_bitclk_i,
    output logic                   conv_port_bitclk_o,
    output logic                   conv_port_bitclk_oe_o,
    input  wire logic              conv_port_frameclk_i,
    output logic                   conv_port_frameclk_o,
    output logic                   conv_port_frameclk_oe_o,
    // Auxiliary serial port pins
    input  wire logic              aux_port_bitclk_i,
    output logic                   aux_port_bitclk_o,
    output logic                   aux_port_bitclk_oe_o,
    input  wire logic              aux_port_frameclk_i,
    output logic                   aux_port_frameclk_o,
    output logic                   aux_port_frameclk_oe_o,
    // Recovered master clock
    input  wire logic              rec_mclk_i,
    output logic                   recovered_mclk_out_o,
    output logic                   recovered_mclk_out_oe_o,
    // Controls to the datapath
    output sfm_deemph_t            deemph_sel_o,
    output sfm_fmt_t               adc_format_o,
    output sfm_fmt_t               dac_format_o,
    output logic                   aux_word16_o,
    output logic                   conv_word16_o,
    output logic                   ext_adc_bitclk_o,
    output logic                   rolloff_slow_o,
    output logic                   hpf_hold_o,
    output logic [103:0]           mix_live_o,
    output logic                   conv_bitclk_o,
    output logic                   conv_frameclk_o,
    output logic                   aux_bitclk_o,
    output logic                   aux_frameclk_o
);

    localparam int NMIX = 13;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [6:0] decode(input logic [ADDR_W-1:0] a);
        logic [5:0] idx;
        logic       hit;
        idx = a[7:2];
        hit = (a[1:0] == 2'h0) && (
              idx == `SFM_IDX_FUNC_MODE || idx == `SFM_IDX_FORMAT ||
              idx == `SFM_IDX_MISC      || idx == `SFM_IDX_CLK_CTRL ||
              idx == `SFM_IDX_RX_MODE   || idx == `SFM_IDX_STATUS ||
              (idx >= `SFM_IDX_MIX_FIRST && idx <= `SFM_IDX_MIX_LAST));
        return {hit, idx};
    endfunction

    function automatic logic [1:0] keep_valid(input logic [1:0] old_v, input logic [1:0] new_v);
        return (new_v == `SFM_CODE_RSVD) ? old_v : new_v;
    endfunction

    function automatic sfm_fmt_t eff_format(input logic [1:0] ol, input logic [1:0] interface_format_sel);
        sfm_fmt_t f;
        f = SFM_FMT_I2S;
        unique case (ol)
            2'h1: f = SFM_FMT_OL1;
            2'h2: f = SFM_FMT_OL2;
            default: begin
                unique case (interface_format_sel)
                    2'h0:    f = SFM_FMT_LJ;
                    2'h2:    f = SFM_FMT_RJ;
                    default: f = SFM_FMT_I2S;
                endcase
            end
        endcase
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              wr_fire;
    logic [6:0]        wr_dec;
    logic              wr_hit;
    logic [5:0]        wr_idx;

    assign s_axi_awready = !aw_have;
    assign s_axi_wready  = !w_have;
    assign wr_fire       = aw_have && w_have && !s_axi_bvalid;
    assign wr_dec        = decode(aw_addr);
    assign wr_idx        = wr_dec[5:0];
    assign wr_hit        = wr_fire && wr_dec[6] && w_lane0;

    // Address and data may arrive in either order
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && !aw_have) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            w_have  <= 1'b0;
            w_byte  <= `SFM_RST_BYTE;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && !w_have) begin
            w_have  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SFM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_dec[6] ? `SFM_RESP_OKAY : `SFM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic       dac_deemph_enable;
    logic       rx_deemph_enable;
    logic       force_pll_lock;
    logic [1:0] manual_deemph_rate;
    logic [7:0] fmt_reg;
    logic [7:0] misc_reg;
    logic [7:0] mix_stage [NMIX];
    logic [7:0] mix_live  [NMIX];

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dac_deemph_enable <= 1'b0;
            rx_deemph_enable  <= 1'b0;
        end else if (wr_hit && wr_idx == `SFM_IDX_FUNC_MODE) begin
            dac_deemph_enable <= w_byte[`SFM_B_DAC_DEEMPH_ENABLE];
            rx_deemph_enable  <= w_byte[`SFM_B_RX_DEM];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            force_pll_lock <= 1'b0;
        end else if (wr_hit && wr_idx == `SFM_IDX_CLK_CTRL) begin
            force_pll_lock <= w_byte[`SFM_B_FORCE_LOCK];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            manual_deemph_rate <= `SFM_RATE_NONE;
        end else if (wr_hit && wr_idx == `SFM_IDX_RX_MODE && w_byte[`SFM_F_MAN_RATE] != `SFM_RATE_NONE) begin
            manual_deemph_rate <= w_byte[`SFM_F_MAN_RATE];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fmt_reg <= `SFM_RST_FORMAT;
        end else if (wr_hit && wr_idx == `SFM_IDX_FORMAT) begin
            fmt_reg[`SFM_F_DIF]    <= keep_valid(fmt_reg[`SFM_F_DIF], w_byte[`SFM_F_DIF]);
            fmt_reg[`SFM_F_ADC_SINGLE_LINE_SEL] <= keep_valid(fmt_reg[`SFM_F_ADC_SINGLE_LINE_SEL], w_byte[`SFM_F_ADC_SINGLE_LINE_SEL]);
            fmt_reg[`SFM_F_DAC_SINGLE_LINE_SEL] <= keep_valid(fmt_reg[`SFM_F_DAC_SINGLE_LINE_SEL], w_byte[`SFM_F_DAC_SINGLE_LINE_SEL]);
            fmt_reg[1:0]           <= w_byte[1:0];
        end
    end

    // Reserved bit 5 always reads zero
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            misc_reg <= `SFM_RST_MISC;
        end else if (wr_hit && wr_idx == `SFM_IDX_MISC) begin
            misc_reg <= {w_byte[7:6], 1'b0, w_byte[4:0]};
        end
    end

    // Live copies follow staged ones unless held
    genvar m;
    generate
        for (m = 0; m < NMIX; m++) begin : g_mix
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    mix_stage[m] <= `SFM_RST_BYTE;
                end else if (wr_hit && wr_idx == `SFM_IDX_MIX_FIRST + 6'(m)) begin
                    mix_stage[m] <= w_byte;
                end
            end
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    mix_live[m] <= `SFM_RST_BYTE;
                end else if (!misc_reg[`SFM_B_HOLD]) begin
                    mix_live[m] <= mix_stage[m];
                end
            end
            assign mix_live_o[8*m +: 8] = mix_live[m];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Port clocking, 0 aux, 1 converter

    logic [1:0] pin_bclk;
    logic [1:0] pin_lrck;
    logic [1:0] role;
    logic [1:0] gen_bclk;
    logic [1:0] gen_lrck;
    logic [1:0] eff_bclk;
    logic [1:0] eff_lrck;
    logic [1:0] frame_lost;

    assign pin_bclk = {conv_port_bitclk_i, aux_port_bitclk_i};
    assign pin_lrck = {conv_port_frameclk_i, aux_port_frameclk_i};
    assign role     = {misc_reg[`SFM_B_CONV_ROLE], misc_reg[`SFM_B_AUX_ROLE]};

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            logic [2:0]  bclk_sync;
            logic [2:0]  lrck_sync;
            logic [7:0]  div_cnt;
            logic [7:0]  bit_cnt;
            logic        bclk_q;
            logic        lrck_q;
            logic [31:0] tmo_cnt;
            logic        lost_q;

            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    bclk_sync <= 3'h0;
                    lrck_sync <= 3'h0;
                end else begin
                    bclk_sync <= {bclk_sync[1:0], pin_bclk[p]};
                    lrck_sync <= {lrck_sync[1:0], pin_lrck[p]};
                end
            end

            // Master clocks come from dividing the reference clock
            always_ff @(posedge ref_clk_i) begin
                if (srst_i || !role[p]) begin
                    div_cnt <= 8'h00;
                    bit_cnt <= 8'h00;
                    bclk_q  <= 1'b0;
                    lrck_q  <= 1'b0;
                end else if (div_cnt == 8'(BCLK_HALF - 1)) begin
                    div_cnt <= 8'h00;
                    bclk_q  <= !bclk_q;
                    if (bclk_q) begin
                        if (bit_cnt == 8'(HALF_FRAME - 1)) begin
                            bit_cnt <= 8'h00;
                            lrck_q  <= !lrck_q;
                        end else begin
                            bit_cnt <= bit_cnt + 8'h01;
                        end
                    end
                end else begin
                    div_cnt <= div_cnt + 8'h01;
                end
            end

            // Slave port with no frame edges is lost
            always_ff @(posedge ref_clk_i) begin
                if (srst_i || role[p] || (lrck_sync[2] != lrck_sync[1])) begin
                    tmo_cnt <= '0;
                    lost_q  <= 1'b0;
                end else if (tmo_cnt == 32'(FRAME_TMO_CYC - 1)) begin
                    lost_q  <= 1'b1;
                end else begin
                    tmo_cnt <= tmo_cnt + 32'h0000_0001;
                end
            end

            assign gen_bclk[p]   = bclk_q;
            assign gen_lrck[p]   = lrck_q;
            assign eff_bclk[p]   = role[p] ? bclk_q : bclk_sync[1];
            assign eff_lrck[p]   = role[p] ? lrck_q : lrck_sync[1];
            assign frame_lost[p] = lost_q;
        end
    endgenerate

    assign aux_port_bitclk_o        = gen_bclk[0];
    assign aux_port_frameclk_o      = gen_lrck[0];
    assign aux_port_bitclk_oe_o     = role[0];
    assign aux_port_frameclk_oe_o   = role[0];
    assign conv_port_bitclk_o       = gen_bclk[1];
    assign conv_port_frameclk_o     = gen_lrck[1];
    assign conv_port_bitclk_oe_o    = role[1];
    assign conv_port_frameclk_oe_o  = role[1];

    ////////////////////////////////////////////////////////////////////////////
    // Datapath controls

    logic [1:0] mclk_sync;
    logic [1:0] use_rate;
    logic       want_deemph;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mclk_sync <= 2'h0;
        end else begin
            mclk_sync <= {mclk_sync[0], rec_mclk_i};
        end
    end

    assign recovered_mclk_out_oe_o = !misc_reg[`SFM_B_HIZ_MCLK];

    // Forced lock takes the manual rate in place of detection
    assign use_rate    = force_pll_lock ? manual_deemph_rate : detected_rate_i;
    assign want_deemph = dac_deemph_enable || (rx_deemph_enable && rx_emphasis_i);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            deemph_sel_o <= SFM_DEEMPH_OFF;
        end else if (!want_deemph) begin
            deemph_sel_o <= SFM_DEEMPH_OFF;
        end else begin
            unique case (use_rate)
                `SFM_RATE_32K: deemph_sel_o <= SFM_DEEMPH_32K;
                `SFM_RATE_44K: deemph_sel_o <= SFM_DEEMPH_44K;
                `SFM_RATE_48K: deemph_sel_o <= SFM_DEEMPH_48K;
                default:       deemph_sel_o <= SFM_DEEMPH_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            adc_format_o         <= SFM_FMT_I2S;
            dac_format_o         <= SFM_FMT_I2S;
            aux_word16_o         <= 1'b0;
            conv_word16_o        <= 1'b0;
            ext_adc_bitclk_o     <= 1'b0;
            rolloff_slow_o       <= 1'b0;
            hpf_hold_o           <= 1'b0;
            recovered_mclk_out_o <= 1'b0;
            conv_bitclk_o        <= 1'b0;
            conv_frameclk_o      <= 1'b0;
            aux_bitclk_o         <= 1'b0;
            aux_frameclk_o       <= 1'b0;
        end else begin
            adc_format_o         <= eff_format(fmt_reg[`SFM_F_ADC_SINGLE_LINE_SEL], fmt_reg[`SFM_F_DIF]);
            dac_format_o         <= eff_format(fmt_reg[`SFM_F_DAC_SINGLE_LINE_SEL], fmt_reg[`SFM_F_DIF]);
            aux_word16_o         <= (fmt_reg[`SFM_F_DIF] == 2'h2) && fmt_reg[`SFM_B_AUX_RJ16];
            conv_word16_o        <= (fmt_reg[`SFM_F_DIF] == 2'h2) && fmt_reg[`SFM_B_CONV_RJ16];
            ext_adc_bitclk_o     <= misc_reg[`SFM_B_EXT_SCLK] ? eff_bclk[1] : eff_bclk[0];
            rolloff_slow_o       <= misc_reg[`SFM_B_ROLLOFF];
            hpf_hold_o           <= misc_reg[`SFM_B_HPF_HOLD];
            recovered_mclk_out_o <= mclk_sync[1];
            conv_bitclk_o        <= eff_bclk[1];
            conv_frameclk_o      <= eff_lrck[1];
            aux_bitclk_o         <= eff_bclk[0];
            aux_frameclk_o       <= eff_lrck[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    logic [6:0] rd_dec;
    logic [7:0] rd_byte;
    logic [5:0] rd_idx;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_dec        = decode(s_axi_araddr);
    assign rd_idx        = rd_dec[5:0];

    // Mixing reads return staged values
    always_comb begin
        rd_byte = `SFM_RST_BYTE;
        if (rd_idx >= `SFM_IDX_MIX_FIRST && rd_idx <= `SFM_IDX_MIX_LAST) begin
            rd_byte = mix_stage[4'(rd_idx - `SFM_IDX_MIX_FIRST)];
        end else if (rd_idx == `SFM_IDX_FUNC_MODE) begin
            rd_byte = {6'h00, dac_deemph_enable, rx_deemph_enable};
        end else if (rd_idx == `SFM_IDX_FORMAT) begin
            rd_byte = fmt_reg;
        end else if (rd_idx == `SFM_IDX_MISC) begin
            rd_byte = misc_reg;
        end else if (rd_idx == `SFM_IDX_CLK_CTRL) begin
            rd_byte = {7'h00, force_pll_lock};
        end else if (rd_idx == `SFM_IDX_RX_MODE) begin
            rd_byte = {2'h0, manual_deemph_rate, 4'h0};
        end else if (rd_idx == `SFM_IDX_STATUS) begin
            rd_byte = {1'b0, adc_format_o, frame_lost, deemph_sel_o};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SFM_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_dec[6] ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            s_axi_rresp  <= rd_dec[6] ? `SFM_RESP_OKAY : `SFM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// file: sim/sfm_ctrl_checker.sv
// Serial format block assertions
`timescale 1ns/1ps
module sfm_ctrl_checker (
    // Clock, reset and bus handshakes
    input wire logic        ref_clk_i, srst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    // Port clock pins
    input wire logic        conv_port_bitclk_o, conv_port_bitclk_oe_o, conv_port_frameclk_o,
    input wire logic        aux_port_bitclk_o, aux_port_bitclk_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence half_high(b);
        b ##1 !b;
    endsequence
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    conv_clk_a: assert property (
        conv_port_bitclk_oe_o && $rose(conv_port_bitclk_o) |=> half_high(conv_port_bitclk_o) or !conv_port_bitclk_oe_o)
        else $error("conv bit clock period wrong");
    aux_clk_a: assert property (
        aux_port_bitclk_oe_o && $rose(aux_port_bitclk_o) |=> half_high(aux_port_bitclk_o) or !aux_port_bitclk_oe_o)
        else $error("aux bit clock period wrong");
    conv_idle_a: assert property (
        !conv_port_bitclk_oe_o && !$past(conv_port_bitclk_oe_o) |-> !conv_port_bitclk_o && !conv_port_frameclk_o)
        else $error("slave divider not idle");
    frame_edge_a: assert property (
        conv_port_bitclk_oe_o && $changed(conv_port_frameclk_o) |-> $fell(conv_port_bitclk_o))
        else $error("frame clock off bit clock edge");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_ans_a: assert property (write_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
endmodule

// file: sim/sfm_port_peer.sv
// Audio processor model clocking a slave serial port
`timescale 1ns/1ps
module sfm_port_peer (
    input  wire logic ref_clk_i,
    input  wire logic run_i,
    input  wire logic slow_i,
    output logic      bc,
    output logic      fc
);
    logic [1:0] div;
    logic [1:0] bits;
    initial {div, bits, bc, fc} = '0;
    // Clocks stand still while run_i is low
    always @(posedge ref_clk_i) if (run_i) begin
        div <= div + 2'h1;
        if (div == (slow_i ? 2'h3 : 2'h1)) begin
            div <= 2'h0;
            bc <= !bc;
            bits <= bits + {1'b0, bc};
            if (bc && bits == 2'h3) fc <= !fc;
        end
    end
endmodule

// file: sim/serial_format_and_misc_control_test.sv
// Serial format block bench
`timescale 1ns/1ps
module serial_format_and_misc_control_test;
    import sfm_pkg::*;
    logic ref_clk_i, srst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_emphasis_i, rec_mclk_i, conv_port_bitclk_i;
    logic conv_port_bitclk_o, conv_port_bitclk_oe_o, conv_port_frameclk_i, conv_port_frameclk_o, aux_port_bitclk_i;
    logic conv_port_frameclk_oe_o, aux_port_bitclk_o, aux_port_bitclk_oe_o, aux_port_frameclk_i, aux_port_frameclk_o;
    logic aux_port_frameclk_oe_o, recovered_mclk_out_o, recovered_mclk_out_oe_o, aux_word16_o, conv_word16_o;
    logic ext_adc_bitclk_o, rolloff_slow_o, hpf_hold_o, conv_bitclk_o, conv_frameclk_o, aux_bitclk_o, aux_frameclk_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr, v;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, detected_rate_i, e_dif, e_adc, e_dac, man;
    logic [103:0] mix_live_o;
    sfm_deemph_t deemph_sel_o;
    sfm_fmt_t adc_format_o, dac_format_o;
    logic [2:0] fa, fd;
    logic run, slow, cb, cf, ab, af;
    logic [33:0] q[$];
    int fail_count, n_compared, seed, i;
    assign conv_port_bitclk_i = conv_port_bitclk_oe_o ? conv_port_bitclk_o : cb;
    assign conv_port_frameclk_i = conv_port_frameclk_oe_o ? conv_port_frameclk_o : cf;
    assign aux_port_bitclk_i = aux_port_bitclk_oe_o ? aux_port_bitclk_o : ab;
    assign aux_port_frameclk_i = aux_port_frameclk_oe_o ? aux_port_frameclk_o : af;
    sfm_ctrl #(.HALF_FRAME(4), .FRAME_TMO_CYC(50)) dut (.*);
    sfm_port_peer conv_peer (.ref_clk_i, .run_i(run), .slow_i(slow), .bc(cb), .fc(cf));
    sfm_port_peer aux_peer (.ref_clk_i, .run_i(run), .slow_i(!slow), .bc(ab), .fc(af));
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = !ref_clk_i;
    end
    initial begin
        #800_000;
        fail_count++;
        end_sim;
    end
    always @(posedge ref_clk_i) rec_mclk_i <= !rec_mclk_i;
    always @(posedge ref_clk_i) if (s_axi_rvalid && s_axi_rready) chk("read", q.pop_front(), {s_axi_rresp, s_axi_rdata});
    task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        {s_axi_awaddr, s_axi_wdata} <= {a, 24'h00_0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge ref_clk_i);
        chk("bresp", 2'h0, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge ref_clk_i);
        q.push_back(e);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge ref_clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        seed = 32'h2ce3_5f44;
        srst_i = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_emphasis_i, rec_mclk_i} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, detected_rate_i, run, slow, fail_count, n_compared} = '0;
        s_axi_wstrb = 4'hf;
        {e_dif, e_adc, e_dac, man} = 8'h40;
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(8'h10, 34'h0_0000_0040);
        rd(8'h14, 34'h0_0000_0000);
        rd(8'h08, 34'h2_0000_0000);
        for (i = 0; i < 16; i++) begin
            v = {i[3:0], 4'($random(seed))};
            if (v[7:6] != 2'h3) e_dif = v[7:6];
            if (v[5:4] != 2'h3) e_adc = v[5:4];
            if (v[3:2] != 2'h3) e_dac = v[3:2];
            fa = e_adc != 2'h0 ? 3'(e_adc) + 3'h2 : 3'(e_dif);
            fd = e_dac != 2'h0 ? 3'(e_dac) + 3'h2 : 3'(e_dif);
            wr(8'h10, v);
            rd(8'h10, {26'h000_0000, e_dif, e_adc, e_dac, v[1:0]});
            chk("adc fmt", fa, adc_format_o);
            chk("dac fmt", fd, dac_format_o);
            chk("w16", {v[1:0] & {2{e_dif == 2'h2}}}, {aux_word16_o, conv_word16_o});
        end
        run <= 1'b1;
        for (i = 0; i < 8; i++) begin
            v = (8'($random(seed)) & 8'hcc) | 8'(i[1:0]);
            slow <= i[2];
            wr(8'h14, v);
            rd(8'h14, {26'h000_0000, v});
            chk("misc", {!v[6], v[3:0]}, {recovered_mclk_out_oe_o, rolloff_slow_o, hpf_hold_o,
                conv_port_frameclk_oe_o, aux_port_bitclk_oe_o});
            repeat (40) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            fd = v[7] ? conv_bitclk_o : aux_bitclk_o;
            chk("ext clk", fd[0], ext_adc_bitclk_o);
        end
        wr(8'h14, 8'h00);
        run <= 1'b0;
        repeat (90) @(posedge ref_clk_i);
        rd(8'h80, {26'h000_0000, 1'b0, fa, 4'hc});
        run <= 1'b1;
        for (i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            {rx_emphasis_i, detected_rate_i} <= v[2:0];
            wr(8'h0c, {6'h00, v[4:3]});
            wr(8'h18, {7'h00, v[5]});
            wr(8'h78, {2'h0, v[7:6], 4'h0});
            if (v[7:6] != 2'h0) man = v[7:6];
            @(negedge ref_clk_i);
            chk("deemph", (v[4] | (v[3] & v[2])) ? (v[5] ? man : v[1:0]) : 2'h0, deemph_sel_o);
        end
        wr(8'h14, 8'h10);
        wr(8'h3c, 8'ha5);
        chk("frozen", 8'h00, mix_live_o[7:0]);
        wr(8'h14, 8'h00);
        rd(8'h3c, 34'h0_0000_00a5);
        chk("live", 8'ha5, mix_live_o[7:0]);
        end_sim;
    end
endmodule
bind sfm_ctrl sfm_ctrl_checker chk_i (.*);
